// ==== acs_pkg.sv ====
// Package of register map, field layout and timing constants for the converter sequencer.
package acs_pkg;

	// Register word indices as printed; byte address is four times the index.
	localparam logic [7:0] ctrl_main_idx   = 8'h1f;
	localparam logic [7:0] port_cfg_idx    = 8'h9f;
	localparam logic [7:0] result_idx      = 8'h1e;
	localparam logic [7:0] irq_status_idx  = 8'h0c;
	localparam logic [7:0] irq_enable_idx  = 8'h8c;
	localparam logic [7:0] pin_dir_idx     = 8'h85;
	localparam logic [7:0] analog_in_idx   = 8'h20;

	// Control register field positions.
	localparam int clk_sel_lsb  = 6;
	localparam int chan_sel_lsb = 3;
	localparam int go_bit       = 2;
	localparam int power_bit    = 0;

	// Interrupt flag and enable bit position.
	localparam int done_flag_bit = 6;

	// Reset values.
	localparam logic [7:0] ctrl_main_rst = 8'h00;
	localparam logic [2:0] port_cfg_rst  = 3'h0;
	localparam logic [5:0] pin_dir_rst   = 6'h3f;

	// Per-bit period in oscillator periods for clock select codes 00, 01 and 10.
	localparam logic [5:0] tad_div_00 = 6'h02;
	localparam logic [5:0] tad_div_01 = 6'h08;
	localparam logic [5:0] tad_div_10 = 6'h20;

	// Conversion length and abort recovery, in per-bit periods.
	localparam logic [3:0] conv_periods = 4'h9;
	localparam logic [3:0] wait_periods = 4'h2;

	// Nominal internal RC per-bit time and its cycle count at 200 MHz.
	localparam int rc_tad_ns   = 4000;
	localparam int clk_ns      = 5;
	localparam int rc_tad_cyc  = rc_tad_ns / clk_ns;

	// Bus responses.
	localparam logic [1:0] resp_okay   = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_conv = 3'b010,
		st_wait = 3'b100
	} acs_state_type;

endpackage : acs_pkg

// ==== acs_tad_gen.sv ====
// Per-bit conversion period enable generator.
`timescale 1ns/1ps
module acs_tad_gen #(
	parameter int rc_cycles = acs_pkg::rc_tad_cyc
) (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Control
	input  wire logic       run,
	input  wire logic [1:0] clk_sel,
	// Output
	output logic            tad_tick
);
	// The counter must span both the RC count and the slowest oscillator divide.
	localparam int slow_div = int'(acs_pkg::tad_div_10);
	localparam int cw       = $clog2(((rc_cycles > slow_div) ? rc_cycles : slow_div) + 1);

	logic [cw-1:0] cnt_r;
	logic [cw-1:0] limit;

	// Codes 00/01/10 divide the oscillator; 11 stands in for the internal RC. [R01] [R20] [R17]
	assign limit = (clk_sel == 2'h0) ? cw'(acs_pkg::tad_div_00) :
	               (clk_sel == 2'h1) ? cw'(acs_pkg::tad_div_01) :
	               (clk_sel == 2'h2) ? cw'(acs_pkg::tad_div_10) : cw'(rc_cycles);

	assign tad_tick = run && (cnt_r == limit - cw'(1));

	always_ff @(posedge aclk) begin
		if (!aresetn || !run || tad_tick) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + cw'(1);
		end
	end
endmodule : acs_tad_gen

// ==== acs_top.sv ====
// AXI4-Lite register slave and conversion sequencer of the 8-bit converter.
// Operation
// R01 - Two-bit clock select picks 2, 8, 32 oscillator periods or RC.
// R02 - Bits 5..3 select one of five analog channels, codes 0 to 4.
// R03 - Setting go while powered starts converting the selected channel.
// R04 - Completion loads result, clears go, sets done flag together.
// R05 - Bit 0 powers converter; zero shuts it off.
// R06 - Port config bits 7..3 and control bit 1 read zero.
// R07 - Port config field decodes pins as analog, digital or reference.
// R08 - Result register is not initialised by reset.
// R09 - One conversion takes nine per-bit periods.
// R10 - Software waits two periods after a conversion before next acquisition.
// R11 - Software keeps the per-bit period between 1.6 and 6.4 us.
// R12 - Software waits acquisition time after changing channel.
// R13 - Software sets analog pins as inputs.
// R14 - For interrupts, software clears done flag then sets enables.
// R15 - Software polls go or waits for interrupt.
// R16 - Software reads result and clears done flag before next start.
// R17 - Clock select 11 uses the internal RC period.
// R18 - Clearing go mid-conversion aborts and keeps the old result.
// R19 - Reset returns registers to reset values and aborts conversion.
// R20 - Codes 00, 01, 10 give 2, 8, 32 oscillator periods.
`timescale 1ns/1ps
module acs_top #(
	parameter int rc_cycles = acs_pkg::rc_tad_cyc
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// Write data channel
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// Write response channel
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read address channel
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// Read data channel
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Analog front end
	input  wire logic [7:0]  sample_code,
	output logic [2:0]       input_channel_select,
	output logic             converter_power_on,
	output logic             sample_hold,
	// Pin configuration
	output logic [4:0]       pin_analog,
	output logic             port_a_pin3_is_ref,
	// Interrupt request
	output logic             conversion_irq
);
	// Control and status registers.
	logic [1:0]  conv_clock_select_r;
	logic [2:0]  chan_sel_r;
	logic        go_r;
	logic        power_r;
	logic [2:0]  port_config_select_r;
	logic [7:0]  conversion_result_r;
	logic        conversion_done_flag_r;
	logic        conversion_irq_enable_r;
	logic [5:0]  pin_direction_bits_r;
	logic [7:0]  analog_in_r;
	logic [3:0]  per_cnt_r;
	acs_pkg::acs_state_type state_r;
	acs_pkg::acs_state_type state_nxt;

	// Bus slave holding registers.
	logic        aw_full_r;
	logic [11:0] aw_addr_r;
	logic        w_full_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	function automatic logic [7:0] word_index(input logic [11:0] addr);
		word_index = addr[9:2];
	endfunction : word_index

	// Write decode: fires once both address and data are held and no write response is pending.
	logic        wr_fire;
	logic [7:0]  wr_idx;
	logic [7:0]  wr_byte;
	logic        wr_main;
	logic        wr_cfg;
	logic        wr_res;
	logic        wr_ist;
	logic        wr_ien;
	logic        wr_dir;
	logic        wr_ain;
	logic        wr_hit;
	assign wr_fire = aw_full_r && w_full_r && !bvalid_r;
	assign wr_idx  = word_index(aw_addr_r);
	assign wr_byte = w_data_r[7:0];
	assign wr_main = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::ctrl_main_idx);
	assign wr_cfg  = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::port_cfg_idx);
	assign wr_res  = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::result_idx);
	assign wr_ist  = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::irq_status_idx);
	assign wr_ien  = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::irq_enable_idx);
	assign wr_dir  = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::pin_dir_idx);
	assign wr_ain  = wr_fire && w_strb_r[0] && (wr_idx == acs_pkg::analog_in_idx);
	assign wr_hit  = (wr_idx == acs_pkg::ctrl_main_idx) || (wr_idx == acs_pkg::port_cfg_idx)
	              || (wr_idx == acs_pkg::result_idx) || (wr_idx == acs_pkg::irq_status_idx)
	              || (wr_idx == acs_pkg::irq_enable_idx) || (wr_idx == acs_pkg::pin_dir_idx)
	              || (wr_idx == acs_pkg::analog_in_idx);

	// Sequencer control.
	logic tad_tick;
	logic in_conv;
	logic in_wait;
	logic conv_done;
	logic go_start;
	logic go_abort;
	assign in_conv   = (state_r == acs_pkg::st_conv);
	assign in_wait   = (state_r == acs_pkg::st_wait);
	assign conv_done = in_conv && tad_tick && (per_cnt_r == acs_pkg::conv_periods - 4'h1); // [R09]
	// A write that leaves go low, or drops power, ends the conversion early. [R18] [R05]
	assign go_abort  = in_conv && wr_main
	                && (!wr_byte[acs_pkg::go_bit] || !wr_byte[acs_pkg::power_bit]);
	// Go is honoured only with power on; the start waits out any abort recovery. [R03]
	assign go_start  = (state_r == acs_pkg::st_idle) && go_r && power_r;

	// Dropping run on an abort restarts the divider, so the recovery wait spans whole periods.
	acs_tad_gen #(
		.rc_cycles (rc_cycles)
	) u_tad (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.run      ((in_conv || in_wait) && !go_abort),
		.clk_sel  (conv_clock_select_r),
		.tad_tick (tad_tick)
	);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			acs_pkg::st_idle: begin
				if (go_start) begin
					state_nxt = acs_pkg::st_conv;
				end
			end
			acs_pkg::st_conv: begin
				if (go_abort) begin
					state_nxt = acs_pkg::st_wait;
				end else if (conv_done) begin
					state_nxt = acs_pkg::st_idle;
				end
			end
			acs_pkg::st_wait: begin
				if (tad_tick && (per_cnt_r == acs_pkg::wait_periods - 4'h1)) begin
					state_nxt = acs_pkg::st_idle;
				end
			end
			default: state_nxt = acs_pkg::st_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r   <= acs_pkg::st_idle; // [R19]
			per_cnt_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			if (state_nxt != state_r) begin
				per_cnt_r <= 4'h0;
			end else if (tad_tick) begin
				per_cnt_r <= per_cnt_r + 4'h1;
			end
		end
	end

	// Control register; hardware clearing of go on completion wins over a simultaneous software write of go.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conv_clock_select_r  <= acs_pkg::ctrl_main_rst[7:6]; // [R19]
			chan_sel_r           <= acs_pkg::ctrl_main_rst[5:3];
			go_r                 <= acs_pkg::ctrl_main_rst[2];
			power_r              <= acs_pkg::ctrl_main_rst[0];
			port_config_select_r <= acs_pkg::port_cfg_rst;
			pin_direction_bits_r <= acs_pkg::pin_dir_rst;
			conversion_irq_enable_r <= 1'b0;
			analog_in_r          <= 8'h00;
		end else begin
			if (wr_main) begin
				conv_clock_select_r <= wr_byte[acs_pkg::clk_sel_lsb +: 2];  // [R01]
				chan_sel_r          <= wr_byte[acs_pkg::chan_sel_lsb +: 3]; // [R02]
				power_r             <= wr_byte[acs_pkg::power_bit];         // [R05]
				go_r                <= wr_byte[acs_pkg::go_bit] && !conv_done;
			end else if (conv_done || !power_r) begin
				go_r <= 1'b0; // [R04]
			end
			if (wr_cfg) begin
				port_config_select_r <= wr_byte[2:0]; // [R06]
			end
			if (wr_dir) begin
				pin_direction_bits_r <= wr_byte[5:0];
			end
			if (wr_ien) begin
				conversion_irq_enable_r <= wr_byte[acs_pkg::done_flag_bit];
			end
			if (wr_ain) begin
				analog_in_r <= wr_byte;
			end
		end
	end

	// Done flag: completion sets it and wins over a simultaneous software clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			conversion_done_flag_r <= 1'b0;
		end else if (conv_done) begin
			conversion_done_flag_r <= 1'b1; // [R04]
		end else if (wr_ist) begin
			conversion_done_flag_r <= wr_byte[acs_pkg::done_flag_bit];
		end
	end

	// Result has no reset so its power-on content stays unknown; aborts never load it.
	always_ff @(posedge aclk) begin
		if (conv_done) begin
			conversion_result_r <= sample_code; // [R04] [R08] [R18]
		end else if (wr_res) begin
			conversion_result_r <= wr_byte;
		end
	end

	// Pin configuration decode.
	logic [4:0] cfg_analog;
	logic       cfg_ref;
	assign cfg_analog = (port_config_select_r[2:1] == 2'h3) ? 5'h00 :  // [R07]
	                    (port_config_select_r == 3'h4)      ? 5'h0b :
	                    (port_config_select_r == 3'h5)      ? 5'h03 :
	                    (port_config_select_r[0])           ? 5'h17 : 5'h1f;
	assign cfg_ref    = (port_config_select_r == 3'h1) || (port_config_select_r == 3'h3)
	                 || (port_config_select_r == 3'h5); // [R07]

	// Bus channels.
	logic [7:0]  rd_idx;
	logic [31:0] rd_word;
	logic        rd_hit;
	logic [7:0]  main_rd;
	assign main_rd = {conv_clock_select_r, chan_sel_r, go_r, 1'b0, power_r}; // [R06]
	assign rd_idx  = word_index(s_axi_araddr);
	assign rd_hit  = (rd_idx == acs_pkg::ctrl_main_idx) || (rd_idx == acs_pkg::port_cfg_idx)
	              || (rd_idx == acs_pkg::result_idx) || (rd_idx == acs_pkg::irq_status_idx)
	              || (rd_idx == acs_pkg::irq_enable_idx) || (rd_idx == acs_pkg::pin_dir_idx)
	              || (rd_idx == acs_pkg::analog_in_idx);
	assign rd_word = (rd_idx == acs_pkg::ctrl_main_idx)  ? {24'h0, main_rd} :
	                 (rd_idx == acs_pkg::port_cfg_idx)   ? {29'h0, port_config_select_r} :
	                 (rd_idx == acs_pkg::result_idx)     ? {24'h0, conversion_result_r} :
	                 (rd_idx == acs_pkg::irq_status_idx) ? {25'h0, conversion_done_flag_r, 6'h0} :
	                 (rd_idx == acs_pkg::irq_enable_idx) ? {25'h0, conversion_irq_enable_r, 6'h0} :
	                 (rd_idx == acs_pkg::pin_dir_idx)    ? {26'h0, pin_direction_bits_r} :
	                 (rd_idx == acs_pkg::analog_in_idx)  ? {24'h0, analog_in_r} : 32'h0;

	assign s_axi_awready = !aw_full_r;
	assign s_axi_wready  = !w_full_r;
	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_addr_r <= 12'h000;
			w_full_r  <= 1'b0;
			w_data_r  <= 32'h0;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= acs_pkg::resp_okay;
		end else begin
			if (s_axi_awvalid && !aw_full_r) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full_r <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_r) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_r <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r  <= wr_hit ? acs_pkg::resp_okay : acs_pkg::resp_slverr;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= acs_pkg::resp_okay;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_hit ? acs_pkg::resp_okay : acs_pkg::resp_slverr;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	assign input_channel_select = chan_sel_r;       // [R02]
	assign converter_power_on   = power_r;          // [R05]
	assign sample_hold          = in_conv;
	assign pin_analog           = cfg_analog;
	assign port_a_pin3_is_ref   = cfg_ref;
	assign conversion_irq       = conversion_done_flag_r && conversion_irq_enable_r;
endmodule : acs_top

// ==== acs_top_props.sv ====
// Checker of bus handshakes, conversion timing and pin decode at the sequencer ports.
`timescale 1ns/1ps
module acs_top_props (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Converter and pins
	input wire logic        converter_power_on,
	input wire logic        sample_hold,
	input wire logic [4:0]  pin_analog,
	input wire logic        port_a_pin3_is_ref,
	input wire logic        conversion_irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	rst_idle_a: assert property (
		$rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
		else $error("bus not idle after reset");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write response without a held write");
	r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("read data without a taken address");
	start_pwr_a: assert property ($rose(sample_hold) |-> converter_power_on)
		else $error("conversion started while unpowered");
	off_abort_a: assert property (!converter_power_on |=> !sample_hold)
		else $error("conversion runs while unpowered");
	conv_min_a: assert property ($rose(sample_hold) |-> sample_hold[*8])
		else $error("conversion ended too soon");
	conv_max_a: assert property ($rose(sample_hold) |-> ##[1:320] !sample_hold)
		else $error("conversion never ended");
	pin_pair_a: assert property (
		pin_analog[2] == pin_analog[4] && pin_analog[0] == pin_analog[1])
		else $error("paired pins decoded apart");
	ref_keep_a: assert property (port_a_pin3_is_ref |-> pin_analog[1:0] == 2'b11)
		else $error("reference mode lost analog inputs");
	conv_c: cover property ($fell(sample_hold));
	irq_c: cover property ($rose(conversion_irq));
	err_c: cover property (s_axi_bvalid && s_axi_bresp == acs_pkg::resp_slverr);
endmodule : acs_top_props

// ==== acs_front_model.sv ====
// Behavioural analog front end that answers the sequencer's conversions.
`timescale 1ns/1ps
module acs_front_model (
	// Clock
	input  wire logic       aclk,
	// Sequencer side
	input  wire logic [2:0] input_channel_select,
	input  wire logic       converter_power_on,
	input  wire logic       sample_hold,
	// Result code
	output logic [7:0]      sample_code
);
	logic [7:0] spin_r = 8'h00;
	always_ff @(posedge aclk) begin
		spin_r <= spin_r + 8'h3b;
	end
	// Outside a powered hold the code churns, so a stale or early sample shows as a mismatch.
	assign sample_code = (sample_hold && converter_power_on) ?
		{input_channel_select, 5'h0d} : spin_r;
endmodule : acs_front_model

// ==== tb.sv ====
// Self-checking bench of the converter sequencer driven over its register bus.
`timescale 1ns/1ps
module tb;
	localparam int          rc_cyc = 4;
	localparam logic [1:0]  ok = acs_pkg::resp_okay;
	localparam logic [11:0] a_ctrl = {2'b00, acs_pkg::ctrl_main_idx, 2'b00};
	localparam logic [11:0] a_port_config_select = {2'b00, acs_pkg::port_cfg_idx, 2'b00};
	localparam logic [11:0] a_res = {2'b00, acs_pkg::result_idx, 2'b00};
	localparam logic [11:0] a_irqs = {2'b00, acs_pkg::irq_status_idx, 2'b00};
	localparam logic [11:0] a_irqe = {2'b00, acs_pkg::irq_enable_idx, 2'b00};
	localparam logic [11:0] a_pdir = {2'b00, acs_pkg::pin_dir_idx, 2'b00};
	localparam logic [4:0]  pa_exp [8] = '{5'h1f, 5'h17, 5'h1f, 5'h17, 5'h0b, 5'h03, 5'h00, 5'h00};
	localparam logic [7:0]  rf_exp = 8'h2a;
	// Only the RC per-bit period is shrunk, from 800 to 4 cycles, to keep runs short; firmware on the
	// real oscillator keeps the period within 1.6 to 6.4 us.
	localparam int          per [4] = '{2, 8, 32, rc_cyc};
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [11:0] s_axi_araddr = 12'h000;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] s_axi_rdata, rv;
	logic [7:0]  sample_code;
	logic [2:0]  input_channel_select;
	logic        converter_power_on, sample_hold, port_a_pin3_is_ref, conversion_irq;
	logic [4:0]  pin_analog;
	int          errors = 0, compares = 0, run_len = 0, last_len = 0;

	acs_top #(.rc_cycles(rc_cyc)) u_acs_top (.*);
	acs_front_model u_acs_front_model (.*);

	initial begin
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (sample_hold)
			run_len++;
		else if (run_len != 0) begin
			last_len = run_len;
			run_len = 0;
		end
	end

	task automatic stop_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			// A late ready exercises the slave holding its response.
			if (n == 3) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready) && n < 400);
		s_axi_bready <= 1'b0;
		if (n >= 400) errors++;
		check(32'(s_axi_bresp), 32'(er));
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n == 2) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready) && n < 400);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 400) errors++;
	endtask : rd
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		rd(a, rv, rsp);
		check(rv, e);
		check(32'(rsp), 32'(er));
	endtask : rchk
	task automatic poll_done();
		int n;
		n = 0;
		do begin
			rd(a_ctrl, rv, rsp);
			n++;
		end while (rv[acs_pkg::go_bit] !== 1'b0 && n < 200);
		if (n >= 200) errors++;
	endtask : poll_done

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(32'(pin_analog), 32'h1f);
		rchk(a_ctrl, 32'h0, ok);
		rchk(a_port_config_select, 32'h0, ok);
		wr(a_port_config_select, 8'hff, ok);
		rchk(a_port_config_select, 32'h7, ok);
		s_axi_wstrb <= 4'he;
		wr(a_port_config_select, 8'h05, ok);
		s_axi_wstrb <= 4'hf;
		rchk(a_port_config_select, 32'h7, ok);
		rchk(a_pdir, 32'h3f, ok);
		wr(a_pdir, 8'hff, ok);
		rchk(a_pdir, 32'h3f, ok);
		wr(a_ctrl, 8'h02, ok);
		rchk(a_ctrl, 32'h0, ok);
		wr(12'h004, 8'h55, acs_pkg::resp_slverr);
		rchk(12'h004, 32'h0, acs_pkg::resp_slverr);
		for (int i = 0; i < 8; i++) begin
			wr(a_port_config_select, 8'(i), ok);
			check(32'(pin_analog), 32'(pa_exp[i]));
			check(32'(port_a_pin3_is_ref), 32'(rf_exp[i]));
		end
		wr(a_ctrl, 8'h01, ok);
		check(32'(converter_power_on), 32'h1);
		for (int i = 0; i < 5; i++) begin
			wr(a_ctrl, {2'(i), 3'(i), 3'b001}, ok);
			check(32'(input_channel_select), 32'(i));
			repeat (20) @(posedge aclk);
			wr(a_ctrl, {2'(i), 3'(i), 3'b101}, ok);
			poll_done();
			check(32'(last_len > 8 * per[i % 4] && last_len <= 9 * per[i % 4] + 2), 32'h1);
			rchk(a_ctrl, {24'h0, 2'(i), 3'(i), 3'b001}, ok);
			rchk(a_res, {24'h0, 3'(i), 5'h0d}, ok);
			rchk(a_irqs, 32'h40, ok);
			wr(a_irqs, 8'h00, ok);
			repeat (2 * per[i % 4] + 2) @(posedge aclk);
		end
		wr(a_irqs, 8'h40, ok);
		wr(a_irqe, 8'h40, ok);
		check(32'(conversion_irq), 32'h1);
		wr(a_irqe, 8'h00, ok);
		check(32'(conversion_irq), 32'h0);
		wr(a_irqs, 8'h00, ok);
		wr(a_irqe, 8'h40, ok);
		check(32'(conversion_irq), 32'h0);
		wr(a_ctrl, 8'h8d, ok);
		repeat (60) @(posedge aclk);
		check(32'(sample_hold), 32'h1);
		wr(a_ctrl, 8'h89, ok);
		repeat (80) @(posedge aclk);
		rchk(a_res, 32'h8d, ok);
		rchk(a_irqs, 32'h0, ok);
		wr(a_ctrl, 8'h95, ok);
		repeat (60) @(posedge aclk);
		wr(a_ctrl, 8'h90, ok);
		check(32'(converter_power_on), 32'h0);
		repeat (3) @(posedge aclk);
		check(32'(sample_hold), 32'h0);
		repeat (80) @(posedge aclk);
		rchk(a_res, 32'h8d, ok);
		wr(a_ctrl, 8'h04, ok);
		repeat (3) @(posedge aclk);
		check(32'(sample_hold), 32'h0);
		rchk(a_ctrl, 32'h0, ok);
		wr(a_ctrl, 8'h8d, ok);
		repeat (40) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check(32'(sample_hold), 32'h0);
		rchk(a_ctrl, 32'h0, ok);
		check(32'(pin_analog), 32'h1f);
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		stop_test();
	end
endmodule : tb

bind acs_top acs_top_props u_acs_top_props (.*);
